// ### shared/dpm_regs.vh
// Operation
// - Each processor initialises its own mailbox flag before relying on it; here the start-up take always reads the left mailbox, FFFE.
// - In slave role, outside logic holds contention high, or low to block writes.
// - A port seeing contention may stall until the other side finishes.
// - Flag space: enable high, flag select low, A0-A2 address, D0 written.
`ifndef DPM_REGS_VH
`define DPM_REGS_VH

`define DPM_AXI_AW 8
`define DPM_OFF_CTRL 8'h00
`define DPM_OFF_ADDR 8'h04
`define DPM_OFF_WDATA 8'h08
`define DPM_OFF_RDATA 8'h0C
`define DPM_OFF_STATUS 8'h10
`define DPM_OFF_CONFIG 8'h14

`define DPM_CTRL_GO 0
`define DPM_CTRL_OP_LSB 1
`define DPM_CTRL_OP_MSB 3

`define DPM_ST_BUSY 0
`define DPM_ST_DONE 1
`define DPM_ST_CONT_SEEN 2
`define DPM_ST_MAIL_PEND 3
`define DPM_ST_CONT_LIVE 4

`define DPM_CFG_RIGHT 0
`define DPM_CFG_MASTER 1
`define DPM_CFG_INHIBIT 2
`define DPM_CFG_RESET 3'h2

`define DPM_OP_RAM_RD 3'h0
`define DPM_OP_RAM_WR 3'h1
`define DPM_OP_FLAG_RD 3'h2
`define DPM_OP_FLAG_WR 3'h3
`define DPM_OP_MAIL_POST 3'h4
`define DPM_OP_MAIL_TAKE 3'h5

`define DPM_MBOX_LEFT 16'hFFFE
`define DPM_MBOX_RIGHT 16'hFFFF
`define DPM_FLAG_AW 3

`define DPM_RESP_OKAY 2'h0
`define DPM_RESP_SLVERR 2'h2

`define DPM_CLK_MHZ 50
`define DPM_T_STROBE_NS 20
`define DPM_STROBE_CYC (((`DPM_T_STROBE_NS * `DPM_CLK_MHZ) + 999) / 1000)

`endif

// ### core/dpm_pin_seq.v
`timescale 1ns/100ps
`include "dpm_regs.vh"

module dpm_pin_seq (
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire start,
  input wire [2:0] op,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire master_role,
  input wire right_port,
  output wire busy,
  output reg done_q,
  output reg bump_q,
  output reg [15:0] rdata_q,
  output reg [15:0] pin_addr_q,
  output reg [15:0] pin_dq_out_q,
  output reg pin_dq_oe_q,
  input wire [15:0] pin_dq_in,
  output reg pin_ce_n_q,
  output reg pin_rw_n_q,
  output reg pin_oe_n_q,
  output reg flag_space_select_n_q,
  input wire contention_n
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_GATE = 3'h2;
  localparam S_STROBE = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam integer STROBE_CNT = `DPM_STROBE_CYC - 1;
  localparam [3:0] STROBE_LAST = STROBE_CNT[3:0];

  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg is_flag_q;
  reg is_wr_q;
  reg new_flag;
  reg new_wr;
  reg [15:0] new_addr;
  reg [15:0] new_data;
  wire blocked;

  always @* begin
    new_flag = (op == `DPM_OP_FLAG_RD) || (op == `DPM_OP_FLAG_WR);
    new_wr = (op == `DPM_OP_RAM_WR) || (op == `DPM_OP_FLAG_WR) || (op == `DPM_OP_MAIL_POST);
    new_data = wdata;
    new_addr = addr;
    if (new_flag) begin
      new_addr = {13'h0000, addr[`DPM_FLAG_AW-1:0]};
      new_data = {15'h0000, wdata[0]};
    end else if (op == `DPM_OP_MAIL_POST) begin
      new_addr = right_port ? `DPM_MBOX_LEFT : `DPM_MBOX_RIGHT;
    end else if (op == `DPM_OP_MAIL_TAKE) begin
      new_addr = right_port ? `DPM_MBOX_RIGHT : `DPM_MBOX_LEFT;
    end
  end

  // Reads are held off as well: the arbiter does not tell reads from writes
  assign blocked = !is_flag_q && master_role && !contention_n;
  assign busy = (state_q != S_IDLE);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      is_flag_q <= 1'b0;
      is_wr_q <= 1'b0;
      done_q <= 1'b0;
      bump_q <= 1'b0;
      rdata_q <= 16'h0000;
      pin_addr_q <= 16'h0000;
      pin_dq_out_q <= 16'h0000;
      pin_dq_oe_q <= 1'b0;
      pin_ce_n_q <= 1'b1;
      pin_rw_n_q <= 1'b1;
      pin_oe_n_q <= 1'b1;
      flag_space_select_n_q <= 1'b1;
    end else if (clk_en) begin
      done_q <= 1'b0;
      bump_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            is_flag_q <= new_flag;
            is_wr_q <= new_wr;
            pin_addr_q <= new_addr;
            pin_dq_out_q <= new_data;
            pin_ce_n_q <= new_flag;
            flag_space_select_n_q <= !new_flag;
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          state_q <= S_GATE;
        end
        S_GATE: begin
          if (blocked) begin
            bump_q <= 1'b1;
          end else begin
            pin_rw_n_q <= !is_wr_q;
            pin_oe_n_q <= is_wr_q;
            pin_dq_oe_q <= is_wr_q;
            cnt_q <= STROBE_LAST;
            state_q <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (blocked) begin
            // Strobe under contention is discarded by the device, so redo it
            bump_q <= 1'b1;
            pin_rw_n_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
            pin_dq_oe_q <= 1'b0;
            state_q <= S_GATE;
          end else if (cnt_q == 4'h0) begin
            if (!is_wr_q) begin
              rdata_q <= pin_dq_in;
            end
            pin_rw_n_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
            pin_dq_oe_q <= 1'b0;
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HOLD: begin
          // Deselect after every access so the next flag read relatches
          pin_ce_n_q <= 1'b1;
          flag_space_select_n_q <= 1'b1;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### core/dpm_host_ctrl.v
`timescale 1ns/100ps
`include "dpm_regs.vh"

module dpm_host_ctrl (
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [`DPM_AXI_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`DPM_AXI_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire [15:0] dev_addr,
  output wire [15:0] dev_dq_out,
  output wire dev_dq_oe,
  input wire [15:0] dev_dq_in,
  output wire dev_ce_n,
  output wire dev_rw_n,
  output wire dev_oe_n,
  output wire flag_space_select_n,
  input wire mailbox_irq_n,
  input wire contention_in_n,
  output wire contention_out_n,
  output wire contention_oe,
  output wire master_role_sel
);
  reg aw_held_q;
  reg [`DPM_AXI_AW-1:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [2:0] op_q;
  reg [15:0] addr_q;
  reg [15:0] wdata_q;
  reg [2:0] cfg_q;
  reg done_seen_q;
  reg cont_seen_q;
  reg init_q;
  reg go_q;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire [31:0] wmask;
  wire do_write;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire seq_busy;
  wire seq_done;
  wire seq_bump;
  wire [15:0] seq_rdata;
  wire [31:0] wr_bits;
  wire [31:0] status_word;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      assign wmask[8*i+7:8*i] = {8{w_strb_q[i]}};
    end
  endgenerate

  assign wr_bits = w_data_q & wmask;
  assign s_axi_awready = clk_en && !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = clk_en && aw_held_q && w_held_q && !s_axi_bvalid;

  // Device in slave role: our port's contention pin is a write inhibit we drive
  assign master_role_sel = cfg_q[`DPM_CFG_MASTER];
  assign contention_oe = !cfg_q[`DPM_CFG_MASTER];
  assign contention_out_n = !cfg_q[`DPM_CFG_INHIBIT];

  assign status_word = {27'h0000000, !contention_in_n, !mailbox_irq_n,
                        cont_seen_q, done_seen_q, seq_busy};

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `DPM_OFF_CTRL: rd_mux = {28'h0000000, op_q, 1'b0};
      `DPM_OFF_ADDR: rd_mux = {16'h0000, addr_q};
      `DPM_OFF_WDATA: rd_mux = {16'h0000, wdata_q};
      `DPM_OFF_RDATA: rd_mux = {16'h0000, seq_rdata};
      `DPM_OFF_STATUS: rd_mux = status_word;
      `DPM_OFF_CONFIG: rd_mux = {29'h00000000, cfg_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= {`DPM_AXI_AW{1'b0}};
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DPM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DPM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      op_q <= `DPM_OP_RAM_RD;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      cfg_q <= `DPM_CFG_RESET;
      done_seen_q <= 1'b0;
      cont_seen_q <= 1'b0;
      init_q <= 1'b1;
      go_q <= 1'b0;
    end else if (clk_en) begin
      go_q <= 1'b0;
      if (go_q || init_q) begin
        init_q <= 1'b0;
      end
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `DPM_RESP_OKAY : `DPM_RESP_SLVERR;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DPM_RESP_OKAY;
        case (aw_addr_q)
          `DPM_OFF_CTRL: begin
            // A go while an access runs or the start-up take is queued is dropped
            if (wr_bits[`DPM_CTRL_GO] && !seq_busy && !go_q && !init_q) begin
              go_q <= 1'b1;
              op_q <= w_data_q[`DPM_CTRL_OP_MSB:`DPM_CTRL_OP_LSB];
            end
          end
          `DPM_OFF_ADDR: addr_q <= (addr_q & ~wmask[15:0]) | wr_bits[15:0];
          `DPM_OFF_WDATA: wdata_q <= (wdata_q & ~wmask[15:0]) | wr_bits[15:0];
          `DPM_OFF_CONFIG: begin
            if (w_strb_q[0]) begin
              cfg_q <= w_data_q[2:0];
            end
          end
          `DPM_OFF_RDATA: s_axi_bresp <= `DPM_RESP_OKAY;
          `DPM_OFF_STATUS: s_axi_bresp <= `DPM_RESP_OKAY;
          default: s_axi_bresp <= `DPM_RESP_SLVERR;
        endcase
      end
      // Hardware set wins over a write-one clear in the same cycle
      if (do_write && (aw_addr_q == `DPM_OFF_STATUS) && wr_bits[`DPM_ST_DONE]) begin
        done_seen_q <= 1'b0;
      end
      if (seq_done) begin
        done_seen_q <= 1'b1;
      end
      if (do_write && (aw_addr_q == `DPM_OFF_STATUS) && wr_bits[`DPM_ST_CONT_SEEN]) begin
        cont_seen_q <= 1'b0;
      end
      if (seq_bump) begin
        cont_seen_q <= 1'b1;
      end
    end
  end

  dpm_pin_seq u_seq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(go_q || init_q),
    .op(init_q ? `DPM_OP_MAIL_TAKE : op_q),
    .addr(addr_q),
    .wdata(wdata_q),
    .master_role(cfg_q[`DPM_CFG_MASTER]),
    .right_port(cfg_q[`DPM_CFG_RIGHT]),
    .busy(seq_busy),
    .done_q(seq_done),
    .bump_q(seq_bump),
    .rdata_q(seq_rdata),
    .pin_addr_q(dev_addr),
    .pin_dq_out_q(dev_dq_out),
    .pin_dq_oe_q(dev_dq_oe),
    .pin_dq_in(dev_dq_in),
    .pin_ce_n_q(dev_ce_n),
    .pin_rw_n_q(dev_rw_n),
    .pin_oe_n_q(dev_oe_n),
    .flag_space_select_n_q(flag_space_select_n),
    .contention_n(contention_in_n)
  );
endmodule

// ### tb/dpm_host_sva.sv
`timescale 1ns/100ps
module dpm_host_sva (
  input wire core_clk,
  input wire sys_rst,
  input wire [15:0] dev_addr,
  input wire [15:0] dev_dq_out,
  input wire dev_dq_oe,
  input wire dev_ce_n,
  input wire dev_rw_n,
  input wire dev_oe_n,
  input wire flag_space_select_n,
  input wire contention_in_n,
  input wire contention_oe,
  input wire master_role_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_FLAG_CE: assert property (!flag_space_select_n |-> dev_ce_n)
    else $error("flag select with ce");
  AST_FLAG_D0: assert property (
    !flag_space_select_n && dev_dq_oe |-> dev_dq_out[15:1] == 15'h0)
    else $error("flag write upper bits");
  // A RAM write strobe in master role may only start from a clear contention sample
  AST_WR_GATE: assert property (
    $fell(dev_rw_n) && !dev_ce_n && master_role_sel |-> $past(contention_in_n))
    else $error("write under contention");
  AST_WR_ONE: assert property ($fell(dev_rw_n) |=> dev_rw_n && !dev_dq_oe)
    else $error("write strobe length");
  AST_RD_ONE: assert property ($fell(dev_oe_n) |=> $rose(dev_oe_n) && dev_rw_n)
    else $error("read strobe length");
  AST_ADDR_HOLD: assert property (
    !dev_ce_n && !$past(dev_ce_n) |-> $stable(dev_addr))
    else $error("address moved");
  AST_ROLE_PIN: assert property (contention_oe == !master_role_sel)
    else $error("contention pin direction");
  AST_RD_SPACE: assert property (
    !dev_oe_n |-> dev_rw_n && !dev_dq_oe && (dev_ce_n != flag_space_select_n))
    else $error("read without one space");
  AST_WR_DRV: assert property (
    !dev_rw_n |-> dev_dq_oe && dev_oe_n && (dev_ce_n != flag_space_select_n))
    else $error("write without one space");
endmodule

bind dpm_host_ctrl dpm_host_sva chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .dev_addr(dev_addr), .dev_dq_out(dev_dq_out), .dev_dq_oe(dev_dq_oe),
  .dev_ce_n(dev_ce_n), .dev_rw_n(dev_rw_n), .dev_oe_n(dev_oe_n),
  .flag_space_select_n(flag_space_select_n), .contention_in_n(contention_in_n),
  .contention_oe(contention_oe), .master_role_sel(master_role_sel));

// ### tb/dpm_dev_model.sv
`timescale 1ns/100ps
module dpm_dev_model (
  input wire ce_n,
  input wire rw_n,
  input wire oe_n,
  input wire flag_space_select_n,
  input wire [15:0] addr,
  input wire [15:0] dq_w,
  output wire [15:0] dq_r,
  output logic left_mailbox_irq_n,
  input wire role,
  input wire host_cont_n,
  input wire host_cont_oe,
  output wire left_contention_n
);
  logic [15:0] mem [0:65535];
  logic [15:0] sem_rd = 16'h0, last = 16'h0, far_addr = 16'h0;
  logic right_mailbox_irq_n = 1'b0, far_en = 1'b0;
  int own [8] = '{default: 0};
  bit req [3][8];
  // Flags start asserted so a missing start-up clear shows
  initial left_mailbox_irq_n = 1'b0;
  // Far port counts as settled first, so the host side loses
  wire match = !ce_n && far_en && addr == far_addr;
  assign left_contention_n = role ? !match : (host_cont_oe ? host_cont_n : 1'b1);
  assign dq_r = !oe_n && !ce_n ? mem[addr] : !oe_n && !flag_space_select_n ? sem_rd : last;
  always @(posedge oe_n) if (!$isunknown(dq_r)) last = ~dq_r;
  always @(negedge oe_n)
    if (!flag_space_select_n) sem_rd = {16{own[addr[2:0]] != 1}};
  always @(posedge rw_n) begin
    if (!ce_n && left_contention_n) begin
      mem[addr] = dq_w;
      if (addr == 16'hFFFF) right_mailbox_irq_n = 1'b0;
    end
    if (ce_n && !flag_space_select_n) sem_wr(1, addr[2:0], dq_w[0]);
  end
  always @(ce_n, oe_n, addr, left_contention_n)
    if (!ce_n && !oe_n && addr == 16'hFFFE && left_contention_n) left_mailbox_irq_n = 1'b1;
  task automatic sem_wr(input int s, input int i, input bit b);
    if (!b && own[i] == 0) own[i] = s;
    else if (!b && own[i] != s) req[s][i] = 1'b1;
    else if (b && own[i] == s) begin
      own[i] = req[3-s][i] ? 3 - s : 0;
      req[3-s][i] = 1'b0;
    end else if (b) req[s][i] = 1'b0;
  endtask
  task automatic far_wr(input logic [15:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 16'hFFFE) left_mailbox_irq_n = 1'b0;
  endtask
  task automatic far_rd(input logic [15:0] a, output logic [15:0] d);
    d = mem[a];
    if (a == 16'hFFFF) right_mailbox_irq_n = 1'b1;
  endtask
  function automatic bit far_sem(input int i);
    return own[i] != 2;
  endfunction
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
`include "dpm_regs.vh"
module tb_top;
  logic core_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] aa = 8'h0, ra = 8'h0;
  logic [31:0] wd = 32'h0, v;
  logic av = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
  wire aw_rdy, w_rdy, bv, ar_rdy, rv, oe, ce_n, rw_n, oe_n, fs_n, irq_n, c_o, c_oe, role, cont;
  wire [1:0] rresp, bresp;
  wire [31:0] rd;
  wire [15:0] da, dq_o, dq_m;
  logic [1:0] r, wb;
  logic [15:0] x;
  int fail_count = 0, compares = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  dpm_host_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(aw_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(ar_rdy), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .dev_addr(da), .dev_dq_out(dq_o), .dev_dq_oe(oe),
    .dev_dq_in(oe ? dq_o : dq_m), .dev_ce_n(ce_n), .dev_rw_n(rw_n), .dev_oe_n(oe_n),
    .flag_space_select_n(fs_n), .mailbox_irq_n(irq_n), .contention_in_n(cont),
    .contention_out_n(c_o), .contention_oe(c_oe), .master_role_sel(role));
  dpm_dev_model m (.ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .flag_space_select_n(fs_n),
    .addr(da), .dq_w(dq_o), .dq_r(dq_m), .left_mailbox_irq_n(irq_n), .role(role),
    .host_cont_n(c_o), .host_cont_oe(c_oe), .left_contention_n(cont));
  task finish_test;
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {aa, wd, av, wv, bq} <= {a, d, 3'b111};
    forever begin
      @(posedge core_clk);
      if (aw_rdy) av <= 1'b0;
      if (w_rdy) wv <= 1'b0;
      if (bv) break;
    end
    wb = bresp;
    bq <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge core_clk);
    {ra, arv, rq} <= {a, 2'b11};
    forever begin
      @(posedge core_clk);
      if (ar_rdy) arv <= 1'b0;
      if (rv) break;
    end
    d = rd;
    e = rresp;
    rq <= 1'b0;
  endtask
  // Leaves the RDATA word in v
  task op(input logic [2:0] o, input logic [15:0] a, input logic [15:0] d);
    axw(`DPM_OFF_ADDR, {16'h0, a});
    axw(`DPM_OFF_WDATA, {16'h0, d});
    axw(`DPM_OFF_CTRL, {28'h0, o, 1'b1});
    do axr(`DPM_OFF_STATUS, v, r); while (v[1] !== 1'b1);
    axw(`DPM_OFF_STATUS, 32'h2);
    axr(`DPM_OFF_RDATA, v, r);
  endtask
  task t_start;
    do axr(`DPM_OFF_STATUS, v, r); while (v[0] !== 1'b0);
    axw(`DPM_OFF_STATUS, 32'h6);
    chk("w1c resp", wb, 2'h0);
    chk("start clear", irq_n, 1'b1);
    axr(`DPM_OFF_CONFIG, v, r);
    chk("config", v, 32'h2);
    axr(8'h3C, v, r);
    chk("unmapped", r, 2'h2);
    axw(8'h3C, 32'h0);
    chk("unmapped wr", wb, 2'h2);
  endtask
  task t_ram;
    op(`DPM_OP_RAM_WR, 16'hFFFE, 16'hA5C3);
    op(`DPM_OP_RAM_RD, 16'hFFFE, 16'h0);
    chk("mailbox word", v[15:0], 16'hA5C3);
  endtask
  task t_mail;
    op(`DPM_OP_MAIL_POST, 16'h0, 16'h1357);
    chk("right set", m.right_mailbox_irq_n, 1'b0);
    m.far_rd(16'hFFFF, x);
    chk("posted", x, 16'h1357);
    chk("right clear", m.right_mailbox_irq_n, 1'b1);
    m.far_wr(16'hFFFE, 16'h2468);
    chk("left set", m.left_mailbox_irq_n, 1'b0);
    axr(`DPM_OFF_STATUS, v, r);
    chk("pending", v[3], 1'b1);
    op(`DPM_OP_MAIL_TAKE, 16'h0, 16'h0);
    chk("taken", v[15:0], 16'h2468);
    chk("left clear", irq_n, 1'b1);
    axw(`DPM_OFF_CONFIG, 32'h3);
    op(`DPM_OP_MAIL_POST, 16'h0, 16'h7E81);
    chk("right post", m.mem[16'hFFFE], 16'h7E81);
    op(`DPM_OP_MAIL_TAKE, 16'h0, 16'h0);
    chk("right take", v[15:0], 16'h1357);
    axw(`DPM_OFF_CONFIG, 32'h2);
  endtask
  task t_sem;
    op(`DPM_OP_FLAG_WR, 16'h0007, 16'h0);
    op(`DPM_OP_FLAG_RD, 16'h0007, 16'h0);
    chk("own", v[15:0], 16'h0);
    chk("far sees", m.far_sem(7), 1'b1);
    m.sem_wr(2, 7, 1'b0);
    op(`DPM_OP_FLAG_RD, 16'h0007, 16'h0);
    chk("held", v[15:0], 16'h0);
    op(`DPM_OP_FLAG_WR, 16'h0007, 16'hFFFF);
    op(`DPM_OP_FLAG_RD, 16'h0007, 16'h0);
    chk("passed", v[15:0], 16'hFFFF);
    chk("far holds", m.far_sem(7), 1'b0);
    op(`DPM_OP_FLAG_WR, 16'hFFFB, 16'h0);
    op(`DPM_OP_FLAG_WR, 16'hFFFB, 16'h1);
    op(`DPM_OP_FLAG_RD, 16'h0003, 16'h0);
    chk("free", v[15:0], 16'hFFFF);
    chk("far free", m.far_sem(3), 1'b1);
  endtask
  task t_cont;
    m.far_wr(16'h1234, 16'h0F0F);
    m.far_addr = 16'h1234;
    m.far_en = 1'b1;
    fork
      op(`DPM_OP_RAM_WR, 16'h1234, 16'hBEEF);
      begin
        repeat (80) @(posedge core_clk);
        chk("stalled", m.mem[16'h1234], 16'h0F0F);
        m.far_en <= 1'b0;
      end
    join
    chk("retried", m.mem[16'h1234], 16'hBEEF);
    axr(`DPM_OFF_STATUS, v, r);
    chk("seen", v[2], 1'b1);
  endtask
  task t_slave;
    m.far_wr(16'h0040, 16'h0);
    axw(`DPM_OFF_CONFIG, 32'h4);
    chk("slave", role, 1'b0);
    op(`DPM_OP_RAM_WR, 16'h0040, 16'h1111);
    chk("inhibited", m.mem[16'h0040], 16'h0);
    axw(`DPM_OFF_CONFIG, 32'h0);
    m.far_addr = 16'h0040;
    m.far_en = 1'b1;
    op(`DPM_OP_RAM_WR, 16'h0040, 16'h1111);
    chk("no arbitration", m.mem[16'h0040], 16'h1111);
    m.far_en = 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_start;
    t_ram;
    t_mail;
    t_sem;
    t_cont;
    t_slave;
    finish_test;
  end
endmodule
